// ==== design/tlrb_bank.sv ====
// long register bank of a tester station with per-pin control and special registers
// Contract
// - relay bit one closes, zero opens
// - direction one drives pin, zero monitors
// - mask zero suppresses compare, one allows
// - pattern is forced or expected level
// - reference select zero first, one alternate
// - compare bit one fail, zero pass
// - pin select pin, rank, node, conditioner fields
// - fixture ident 12-bit read-only from jumpers
// - statement display 15-bit, drives indicators
// - display shows current or end statement
// - sync bits 0-3 enable sync, isolate pins
// - sync out is control AND pattern
// - force supply magnitude, polarity, range, mode
// - sense clamp magnitude, enable, pos, neg
// - sense bit 10 chooses range or clamp
// - sense mode complements force mode bit
// - panel 15-bit, bits 10-14 drive lamps
// - trip feeds converter, mirrors sense range
// - trip bit 13 selects greater or less
// - dc strobe samples comparator, sets bit 14
// - compare sets on mismatch of a masked-in monitored pin, or by a bus write
// - loads from bus bits 0-14 by rank
`timescale 1ns/1ps
module tlrb_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lrb_write,
  input wire logic lrb_read,
  input wire logic [3:0] lrb_select,
  input wire logic [2:0] lrb_rank,
  input wire logic [14:0] lrb_data,
  output logic [14:0] lrb_read_data,
  output logic lrb_read_valid,
  input wire logic [119:0] pin_sense,
  input wire logic neg_logic,
  input wire logic compare_strobe,
  input wire logic compare_clear,
  input wire logic [11:0] fixture_jumpers,
  input wire logic dc_comparator_above,
  input wire logic dc_strobe,
  output logic [119:0] pin_drive_enable,
  output logic [119:0] pin_force_level,
  output logic [119:0] pin_expect_level,
  output logic [119:0] pin_compare_enable,
  output logic [119:0] pin_alternate_ref,
  output logic [119:0] pin_relay_closed,
  output logic [119:0] pin_fail,
  output logic function_fail,
  output logic [8:0] pin_select,
  output logic [14:0] statement_display,
  output logic [3:0] sync_enable,
  output logic [3:0] sync_out,
  output logic [13:0] force_supply_setting,
  output logic [13:0] measure_sense_setting,
  output logic [14:0] panel_output_lamps,
  output logic [14:0] threshold_trip,
  output logic dc_fail
);

  logic [14:0] dir_bits [8];
  logic [14:0] mask_bits [8];
  logic [14:0] pat_bits [8];
  logic [14:0] ref_bits [8];
  logic [14:0] cmp_bits [8];
  logic [14:0] relay_bits [8];
  logic [8:0] psel;
  logic [14:0] stmt;
  logic [7:0] sync_ctl;
  logic [13:0] force_set;
  logic [12:0] sense_store;
  logic [13:0] sense_set;
  logic [14:0] panel;
  logic [14:0] trip_store;
  logic [14:0] trip_full;
  logic [119:0] sense_meta;
  logic [119:0] sense_sync;
  logic [11:0] ident_meta;
  logic [11:0] ident_sync;
  logic cmp_meta;
  logic cmp_sync;
  logic [14:0] next_read_data;

  // decoded write strobe for one register select code
  function automatic logic wr_hit(input logic we, input logic [3:0] sel, input logic [3:0] code);
    wr_hit = we && (sel == code);
  endfunction

  // pins and the comparator come from outside the clock domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      sense_meta <= '0;
      sense_sync <= '0;
      ident_meta <= '0;
      ident_sync <= '0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      sense_meta <= pin_sense;
      sense_sync <= sense_meta;
      ident_meta <= fixture_jumpers;
      ident_sync <= ident_meta;
      cmp_meta <= dc_comparator_above;
      cmp_sync <= cmp_meta;
    end
  end

  // per-pin rank registers, each rank loaded from the bus word
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int r = 0; r < tlrb_pkg::RANKS; r++) begin
        dir_bits[r] <= tlrb_pkg::RESET_WORD;
        mask_bits[r] <= tlrb_pkg::RESET_WORD;
        pat_bits[r] <= tlrb_pkg::RESET_WORD;
        ref_bits[r] <= tlrb_pkg::RESET_WORD;
        relay_bits[r] <= tlrb_pkg::RESET_WORD;
      end
    end else begin
      if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_DIRECTION)) begin
        dir_bits[lrb_rank] <= lrb_data;
      end
      if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_MASK)) begin
        mask_bits[lrb_rank] <= lrb_data;
      end
      if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_PATTERN)) begin
        pat_bits[lrb_rank] <= lrb_data;
      end
      if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_REFSEL)) begin
        ref_bits[lrb_rank] <= lrb_data;
      end
      if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_RELAY)) begin
        relay_bits[lrb_rank] <= lrb_data;
      end
    end
  end

  // compare results: a strobe mismatch sets a bit and wins over a bus write or clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int r = 0; r < tlrb_pkg::RANKS; r++) begin
        cmp_bits[r] <= tlrb_pkg::RESET_WORD;
      end
    end else begin
      for (int r = 0; r < tlrb_pkg::RANKS; r++) begin
        logic [14:0] keep;
        logic [14:0] miss;
        keep = cmp_bits[r];
        if (compare_clear) begin
          keep = '0;
        end
        if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_COMPARE) && (lrb_rank == 3'(r))) begin
          keep = lrb_data;
        end
        miss = '0;
        if (compare_strobe) begin
          for (int b = 0; b < tlrb_pkg::PINS_PER_RANK; b++) begin
            // only monitored outputs are judged; care bit gates the set
            miss[b] = mask_bits[r][b] && !dir_bits[r][b] &&
                      ((sense_sync[r * 15 + b] ^ neg_logic) != pat_bits[r][b]);
          end
        end
        cmp_bits[r] <= keep | miss;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      psel <= '0;
    end else if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_PIN_SELECT)) begin
      psel <= lrb_data[8:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stmt <= tlrb_pkg::RESET_WORD;
    end else if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_STATEMENT)) begin
      // software loads current or end statement number per mode
      stmt <= lrb_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_ctl <= '0;
    end else if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_SYNC)) begin
      sync_ctl <= lrb_data[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      force_set <= '0;
    end else if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_FORCE)) begin
      force_set <= lrb_data[13:0];
    end
  end

  // range enable bit in the written word picks which field group is open
  always_ff @(posedge mclk) begin
    if (rst) begin
      sense_store <= '0;
    end else if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_SENSE)) begin
      if (lrb_data[tlrb_pkg::SENSE_RANGE_EN_BIT]) begin
        sense_store <= (sense_store & ~tlrb_pkg::SENSE_RANGE_MASK[12:0] & ~tlrb_pkg::SENSE_ENABLE_MASK[12:0]) |
                       (lrb_data[12:0] & (tlrb_pkg::SENSE_RANGE_MASK[12:0] |
                       tlrb_pkg::SENSE_ENABLE_MASK[12:0]));
      end else begin
        sense_store <= (sense_store & ~tlrb_pkg::SENSE_CLAMP_MASK[12:0] & ~tlrb_pkg::SENSE_ENABLE_MASK[12:0]) |
                       (lrb_data[12:0] & tlrb_pkg::SENSE_CLAMP_MASK[12:0]);
      end
    end
  end

  // measure mode is never stored: it cannot drift from the force mode
  always_comb begin
    sense_set = {~force_set[tlrb_pkg::FORCE_MODE_BIT], sense_store};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      panel <= tlrb_pkg::RESET_WORD;
    end else if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_PANEL)) begin
      panel <= lrb_data;
    end
  end

  // trip word: software bits plus the strobe verdict; the strobe wins over a write
  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_store <= tlrb_pkg::RESET_WORD;
    end else begin
      if (wr_hit(lrb_write, lrb_select, tlrb_pkg::SEL_TRIP)) begin
        trip_store <= lrb_data & tlrb_pkg::TRIP_WRITE_MASK;
      end
      if (dc_strobe) begin
        // greater-than criterion fails when below, less-than when above
        trip_store[tlrb_pkg::TRIP_FAIL_BIT] <= trip_store[tlrb_pkg::TRIP_GT_BIT] ?
                                               !cmp_sync : cmp_sync;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dc_fail <= 1'b0;
    end else begin
      dc_fail <= dc_strobe && (trip_store[tlrb_pkg::TRIP_GT_BIT] ? !cmp_sync : cmp_sync);
    end
  end

  always_comb begin
    trip_full = trip_store;
    trip_full[12:11] = sense_store[12:11];
  end

  // read mux: ident is taken straight from the synchronised jumpers
  always_comb begin
    next_read_data = '0;
    unique case (lrb_select)
      tlrb_pkg::SEL_DIRECTION: next_read_data = dir_bits[lrb_rank];
      tlrb_pkg::SEL_MASK: next_read_data = mask_bits[lrb_rank];
      tlrb_pkg::SEL_PATTERN: next_read_data = pat_bits[lrb_rank];
      tlrb_pkg::SEL_REFSEL: next_read_data = ref_bits[lrb_rank];
      tlrb_pkg::SEL_COMPARE: next_read_data = cmp_bits[lrb_rank];
      tlrb_pkg::SEL_RELAY: next_read_data = relay_bits[lrb_rank];
      tlrb_pkg::SEL_PIN_SELECT: next_read_data = {6'h00, psel};
      tlrb_pkg::SEL_FIXTURE: next_read_data = {3'h0, ident_sync};
      tlrb_pkg::SEL_STATEMENT: next_read_data = stmt;
      tlrb_pkg::SEL_SYNC: next_read_data = {7'h00, sync_ctl};
      tlrb_pkg::SEL_FORCE: next_read_data = {1'b0, force_set};
      tlrb_pkg::SEL_SENSE: next_read_data = {1'b0, sense_set};
      tlrb_pkg::SEL_PANEL: next_read_data = panel;
      tlrb_pkg::SEL_TRIP: next_read_data = trip_full;
      default: next_read_data = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lrb_read_data <= '0;
      lrb_read_valid <= 1'b0;
    end else begin
      lrb_read_valid <= lrb_read;
      if (lrb_read) begin
        lrb_read_data <= next_read_data;
      end
    end
  end

  // per-pin outputs flattened rank by rank, pin 0 of rank 0 in bit 0
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_drive_enable <= '0;
      pin_force_level <= '0;
      pin_expect_level <= '0;
      pin_compare_enable <= '0;
      pin_alternate_ref <= '0;
      pin_relay_closed <= '0;
      pin_fail <= '0;
      function_fail <= 1'b0;
    end else begin
      for (int r = 0; r < tlrb_pkg::RANKS; r++) begin
        pin_drive_enable[r * 15 +: 15] <= dir_bits[r];
        pin_force_level[r * 15 +: 15] <= pat_bits[r] & dir_bits[r];
        pin_expect_level[r * 15 +: 15] <= pat_bits[r] & ~dir_bits[r];
        pin_compare_enable[r * 15 +: 15] <= mask_bits[r];
        pin_alternate_ref[r * 15 +: 15] <= ref_bits[r];
        pin_relay_closed[r * 15 +: 15] <= relay_bits[r];
        pin_fail[r * 15 +: 15] <= cmp_bits[r];
      end
      function_fail <= (cmp_bits[0] | cmp_bits[1] | cmp_bits[2] | cmp_bits[3] |
                        cmp_bits[4] | cmp_bits[5] | cmp_bits[6] | cmp_bits[7]) != '0;
    end
  end

  // special register outputs; sync pins of rank 0 pattern drive the pulses
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_select <= '0;
      statement_display <= '0;
      sync_enable <= '0;
      sync_out <= '0;
      force_supply_setting <= '0;
      measure_sense_setting <= '0;
      panel_output_lamps <= '0;
      threshold_trip <= '0;
    end else begin
      pin_select <= psel;
      statement_display <= stmt;
      sync_enable <= sync_ctl[3:0];
      sync_out <= sync_ctl[7:4] & pat_bits[0][3:0];
      force_supply_setting <= force_set;
      measure_sense_setting <= sense_set;
      panel_output_lamps <= panel;
      threshold_trip <= trip_full;
    end
  end

endmodule

// ==== design/tlrb_pkg.sv ====
// constants for the tester long register bank
package tlrb_pkg;
  localparam int DATA_W = 15;
  localparam int RANKS = 8;
  localparam int PINS_PER_RANK = 15;
  localparam int PINS = 120;
  localparam int IDENT_W = 12;
  localparam int SEL_W = 4;
  // register select codes presented with each long-register access
  localparam logic [3:0] SEL_DIRECTION = 4'h0;
  localparam logic [3:0] SEL_MASK = 4'h1;
  localparam logic [3:0] SEL_PATTERN = 4'h2;
  localparam logic [3:0] SEL_REFSEL = 4'h3;
  localparam logic [3:0] SEL_COMPARE = 4'h4;
  localparam logic [3:0] SEL_RELAY = 4'h5;
  localparam logic [3:0] SEL_PIN_SELECT = 4'h6;
  localparam logic [3:0] SEL_FIXTURE = 4'h7;
  localparam logic [3:0] SEL_STATEMENT = 4'h8;
  localparam logic [3:0] SEL_SYNC = 4'h9;
  localparam logic [3:0] SEL_FORCE = 4'ha;
  localparam logic [3:0] SEL_SENSE = 4'hb;
  localparam logic [3:0] SEL_PANEL = 4'hc;
  localparam logic [3:0] SEL_TRIP = 4'hd;
  // pin select fields
  localparam int PSEL_W = 9;
  localparam int PSEL_PIN_LSB = 0;
  localparam int PSEL_RANK_LSB = 4;
  localparam int PSEL_NODE_BIT = 7;
  localparam int PSEL_COND_BIT = 8;
  // sync control fields
  localparam int SYNC_W = 8;
  localparam int SYNC_GEN_LSB = 4;
  // force supply fields
  localparam int FORCE_W = 14;
  localparam int FORCE_POL_BIT = 10;
  localparam int FORCE_RANGE_LSB = 11;
  localparam int FORCE_MODE_BIT = 13;
  // sense level fields
  localparam int SENSE_W = 14;
  localparam int SENSE_CLAMP_EN_BIT = 4;
  localparam int SENSE_CLAMP_POS_BIT = 6;
  localparam int SENSE_CLAMP_NEG_BIT = 7;
  localparam int SENSE_RANGE_EN_BIT = 10;
  localparam int SENSE_RANGE_LSB = 11;
  localparam int SENSE_MODE_BIT = 13;
  localparam logic [13:0] SENSE_CLAMP_MASK = 14'h00df;
  localparam logic [13:0] SENSE_RANGE_MASK = 14'h1800;
  localparam logic [13:0] SENSE_ENABLE_MASK = 14'h0400;
  // threshold trip fields
  localparam int TRIP_POL_BIT = 10;
  localparam int TRIP_RANGE_LSB = 11;
  localparam int TRIP_GT_BIT = 13;
  localparam int TRIP_FAIL_BIT = 14;
  localparam logic [14:0] TRIP_WRITE_MASK = 15'h27ff;
  // panel lamp positions
  localparam int LAMP_PARAM_FAIL = 10;
  localparam int LAMP_EOT = 14;
  // reset values
  localparam logic [14:0] RESET_WORD = 15'h0000;
endpackage

// ==== tb/tb_tester_long_register_bank.sv ====
// self-checking bench for the tester long register bank
`timescale 1ns/1ps
module tb_tester_long_register_bank;
  typedef struct packed {logic [3:0] s; logic [2:0] r; logic [14:0] d; logic [14:0] e;} tlrb_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [119:0] pin_sense = 120'h0;
  logic neg_logic = 1'b0;
  logic compare_strobe = 1'b0;
  logic compare_clear = 1'b0;
  logic [11:0] fixture_jumpers = 12'ha5c;
  logic dc_comparator_above = 1'b0;
  logic dc_strobe = 1'b0;
  logic lrb_write, lrb_read, lrb_read_valid, function_fail, dc_fail, ok;
  logic seen_dc = 1'b0;
  logic [3:0] lrb_select, sync_enable, sync_out;
  logic [2:0] lrb_rank;
  logic [14:0] lrb_data, lrb_read_data, statement_display, panel_output_lamps, threshold_trip, q;
  logic [119:0] pin_drive_enable, pin_force_level, pin_expect_level, pin_compare_enable;
  logic [119:0] pin_alternate_ref, pin_relay_closed, pin_fail;
  logic [8:0] pin_select;
  logic [13:0] force_supply_setting, measure_sense_setting;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  // select, rank, data written, expected read back and port value
  tlrb_row_t rows [0:11] = '{{4'h0, 3'h1, 15'h5a5a, 15'h5a5a}, {4'h1, 3'h7, 15'h7fff, 15'h7fff},
    {4'h1, 3'h0, 15'h0003, 15'h0003}, {4'h3, 3'h0, 15'h0f0f, 15'h0f0f}, {4'h5, 3'h3, 15'h1234, 15'h1234},
    {4'h6, 3'h0, 15'h7fff, 15'h01ff}, {4'h8, 3'h0, 15'h7abc, 15'h7abc}, {4'ha, 3'h0, 15'h7fff, 15'h3fff},
    {4'hc, 3'h0, 15'h7fff, 15'h7fff}, {4'h2, 3'h0, 15'h000f, 15'h000f}, {4'h9, 3'h0, 15'h7fff, 15'h00ff},
    {4'h4, 3'h2, 15'h0155, 15'h0155}};
  always #2.5 mclk = ~mclk;
  tlrb_bank tlrb_bank_i (.mclk, .rst, .lrb_write, .lrb_read, .lrb_select, .lrb_rank, .lrb_data, .lrb_read_data,
    .lrb_read_valid, .pin_sense, .neg_logic, .compare_strobe, .compare_clear, .fixture_jumpers,
    .dc_comparator_above, .dc_strobe, .pin_drive_enable, .pin_force_level, .pin_expect_level,
    .pin_compare_enable, .pin_alternate_ref, .pin_relay_closed, .pin_fail, .function_fail, .pin_select,
    .statement_display, .sync_enable, .sync_out, .force_supply_setting, .measure_sense_setting,
    .panel_output_lamps, .threshold_trip, .dc_fail);
  tlrb_seq_model tlrb_seq_model_i (.mclk, .lrb_write, .lrb_read, .lrb_select, .lrb_rank, .lrb_data,
    .lrb_read_data, .lrb_read_valid);
  function automatic logic [14:0] port_of(input logic [3:0] s, input logic [2:0] r);
    case (s)
      4'h0: return pin_drive_enable[r*15 +: 15];
      4'h1: return pin_compare_enable[r*15 +: 15];
      4'h2: return pin_force_level[r*15 +: 15] | pin_expect_level[r*15 +: 15];
      4'h3: return pin_alternate_ref[r*15 +: 15];
      4'h4: return pin_fail[r*15 +: 15];
      4'h5: return pin_relay_closed[r*15 +: 15];
      4'h6: return {6'h0, pin_select};
      4'h8: return statement_display;
      4'h9: return {7'h0, sync_out, sync_enable};
      4'ha: return {1'h0, force_supply_setting};
      4'hc: return panel_output_lamps;
      default: return 15'h0;
    endcase
  endfunction
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic pulse_compare(input logic clr);
    @(posedge mclk);
    compare_strobe <= !clr;
    compare_clear <= clr;
    @(posedge mclk);
    compare_strobe <= 1'b0;
    compare_clear <= 1'b0;
    settle();
  endtask
  task automatic dc_case(input logic above, input logic fail);
    @(posedge mclk);
    seen_dc <= 1'b0;
    dc_comparator_above <= above;
    // comparator passes a two-flop synchroniser before the strobe may judge it
    repeat (4) @(posedge mclk);
    dc_strobe <= 1'b1;
    @(posedge mclk);
    dc_strobe <= 1'b0;
    settle();
    chk({14'h0, seen_dc}, {14'h0, fail});
    chk({14'h0, threshold_trip[14]}, {14'h0, fail});
  endtask
  always @(posedge mclk) begin
    if (dc_fail === 1'b1) seen_dc <= 1'b1;
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(panel_output_lamps | threshold_trip | pin_fail[14:0], 15'h0);
    chk({1'h0, measure_sense_setting}, 15'h2000);
    foreach (rows[i]) begin
      tlrb_seq_model_i.wr(rows[i].s, rows[i].r, rows[i].d);
      tlrb_seq_model_i.rd(rows[i].s, rows[i].r, q, ok);
      @(negedge mclk);
      chk({14'h0, ok}, 15'h0001);
      chk(q, rows[i].e);
      chk(port_of(rows[i].s, rows[i].r), rows[i].e);
    end
    tlrb_seq_model_i.wr(4'hb, 3'h0, 15'h1cff);
    settle();
    chk({1'h0, measure_sense_setting}, 15'h1c00);
    tlrb_seq_model_i.wr(4'hb, 3'h0, 15'h00df);
    settle();
    chk({1'h0, measure_sense_setting}, 15'h18df);
    tlrb_seq_model_i.wr(4'hd, 3'h0, 15'h7fff);
    settle();
    chk(threshold_trip, 15'h3fff);
    tlrb_seq_model_i.wr(4'ha, 3'h0, 15'h0000);
    settle();
    chk({1'h0, measure_sense_setting}, 15'h38df);
    dc_case(1'b0, 1'b1);
    dc_case(1'b1, 1'b0);
    tlrb_seq_model_i.wr(4'hd, 3'h0, 15'h0000);
    dc_case(1'b1, 1'b1);
    pulse_compare(1'b0);
    chk(pin_fail[14:0], 15'h0003);
    chk(pin_fail[29:15] | {14'h0, !function_fail}, 15'h0);
    neg_logic <= 1'b1;
    pulse_compare(1'b1);
    chk(pin_fail[14:0], 15'h0);
    pulse_compare(1'b0);
    chk(pin_fail[14:0], 15'h0);
    chk(pin_fail[119:105], 15'h7fff);
    tlrb_seq_model_i.wr(4'h2, 3'h0, 15'h000a);
    settle();
    chk({11'h0, sync_out}, 15'h000a);
    // rank 1 mixes inputs and outputs, so the pattern must split into forced and expected levels
    tlrb_seq_model_i.wr(4'h2, 3'h1, 15'h7fff);
    settle();
    chk(pin_force_level[29:15], 15'h5a5a);
    chk(pin_expect_level[29:15], 15'h25a5);
    tlrb_seq_model_i.rd(4'h7, 3'h0, q, ok);
    chk({14'h0, ok}, 15'h0001);
    chk(q, 15'h0a5c);
    tlrb_seq_model_i.rd(4'he, 3'h0, q, ok);
    chk({14'h0, ok}, 15'h0001);
    chk(q, 15'h0);
    close_out();
  end
endmodule

// ==== tb/tlrb_bank_checker.sv ====
// concurrent assertions for the tester long register bank ports
`timescale 1ns/1ps
module tlrb_bank_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lrb_write,
  input wire logic lrb_read,
  input wire logic [3:0] lrb_select,
  input wire logic [14:0] lrb_data,
  input wire logic [14:0] lrb_read_data,
  input wire logic lrb_read_valid,
  input wire logic [11:0] fixture_jumpers,
  input wire logic dc_strobe,
  input wire logic [119:0] pin_drive_enable,
  input wire logic [119:0] pin_force_level,
  input wire logic [119:0] pin_expect_level,
  input wire logic [119:0] pin_fail,
  input wire logic function_fail,
  input wire logic [3:0] sync_out,
  input wire logic [13:0] force_supply_setting,
  input wire logic [13:0] measure_sense_setting,
  input wire logic [14:0] panel_output_lamps,
  input wire logic [14:0] threshold_trip,
  input wire logic dc_fail
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [1:0] rst_hist;
  logic [14:0] panel_word;
  // mirrored outputs lag their source, so relations wait two quiet edges after reset
  wire quiet = (rst_hist == 2'b00);
  always_ff @(posedge mclk) begin
    rst_hist <= {rst_hist[0], rst};
  end
  always_ff @(posedge mclk) begin
    if (lrb_write && lrb_select == tlrb_pkg::SEL_PANEL) begin
      panel_word <= lrb_data;
    end
  end
  property p_force_dir;
    (pin_force_level & ~pin_drive_enable) == 120'h0 && (pin_expect_level & pin_drive_enable) == 120'h0;
  endproperty
  a_force_dir: assert property (p_force_dir) else $error("drive level outside direction");
  property p_sense_mode;
    quiet && $stable(force_supply_setting[13]) |-> measure_sense_setting[13] == !force_supply_setting[13];
  endproperty
  a_sense_mode: assert property (p_sense_mode) else $error("sense mode not complement");
  property p_unused;
    (measure_sense_setting & 14'h0320) == 14'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused sense bits set");
  property p_trip_range;
    quiet && $stable(measure_sense_setting[12:11]) && measure_sense_setting[12:11] == $past(measure_sense_setting[12:11], 2)
      |-> threshold_trip[12:11] == measure_sense_setting[12:11];
  endproperty
  a_trip_range: assert property (p_trip_range) else $error("trip range not mirrored");
  property p_sync;
    quiet && $stable(pin_force_level[3:0] | pin_expect_level[3:0]) |-> (sync_out & ~(pin_force_level[3:0] | pin_expect_level[3:0])) == 4'h0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync without pattern");
  property p_dc_fail;
    dc_fail |-> $past(dc_strobe) || $past(dc_strobe, 2);
  endproperty
  a_dc_fail: assert property (p_dc_fail) else $error("dc fail without strobe");
  property p_read_valid;
    quiet |-> lrb_read_valid == $past(lrb_read);
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read valid timing");
  property p_ident;
    // the jumper synchroniser is flushed by reset, so only judge reads two quiet edges later
    quiet && lrb_read && lrb_select == tlrb_pkg::SEL_FIXTURE && $stable(fixture_jumpers) &&
      fixture_jumpers == $past(fixture_jumpers, 2) && fixture_jumpers == $past(fixture_jumpers, 3)
      |=> lrb_read_data == {3'h0, $past(fixture_jumpers)};
  endproperty
  a_ident: assert property (p_ident) else $error("fixture ident read wrong");
  property p_panel_wr;
    lrb_write && lrb_select == tlrb_pkg::SEL_PANEL |-> ##3 panel_output_lamps == panel_word;
  endproperty
  a_panel_wr: assert property (p_panel_wr) else $error("panel write not shown");
  property p_fail_or;
    function_fail == (|pin_fail);
  endproperty
  a_fail_or: assert property (p_fail_or) else $error("function fail not OR of pins");
  c_dc: cover property (dc_fail);
  c_read: cover property (lrb_read_valid && lrb_read_data != 15'h0);
  c_fail: cover property (function_fail);
endmodule
bind tlrb_bank tlrb_bank_checker tlrb_bank_checker_i (.mclk, .rst, .lrb_write, .lrb_read, .lrb_select, .lrb_data,
  .lrb_read_data, .lrb_read_valid, .fixture_jumpers, .dc_strobe, .pin_drive_enable, .pin_force_level,
  .pin_expect_level, .pin_fail, .function_fail, .sync_out, .force_supply_setting, .measure_sense_setting,
  .panel_output_lamps, .threshold_trip, .dc_fail);

// ==== tb/tlrb_seq_model.sv ====
// sequencing side model that issues long register writes and reads
`timescale 1ns/1ps
module tlrb_seq_model (
  input wire logic mclk,
  output logic lrb_write,
  output logic lrb_read,
  output logic [3:0] lrb_select,
  output logic [2:0] lrb_rank,
  output logic [14:0] lrb_data,
  input wire logic [14:0] lrb_read_data,
  input wire logic lrb_read_valid
);
  initial begin
    lrb_write = 1'b0;
    lrb_read = 1'b0;
    lrb_select = 4'h0;
    lrb_rank = 3'h0;
    lrb_data = 15'h0;
  end
  // sense bit 13 is never relied on as stored; it follows the force mode
  task automatic wr(input logic [3:0] s, input logic [2:0] r, input logic [14:0] d);
    @(posedge mclk);
    lrb_select <= s;
    lrb_rank <= r;
    lrb_data <= d;
    lrb_write <= 1'b1;
    @(posedge mclk);
    lrb_write <= 1'b0;
    // released bus shows the inverse so a stale word is never taken as fresh
    lrb_data <= ~d;
  endtask
  task automatic rd(input logic [3:0] s, input logic [2:0] r, output logic [14:0] q, output logic ok);
    @(posedge mclk);
    lrb_select <= s;
    lrb_rank <= r;
    lrb_read <= 1'b1;
    @(posedge mclk);
    lrb_read <= 1'b0;
    ok = 1'b0;
    q = 15'h0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge mclk);
      if (lrb_read_valid === 1'b1) begin
        ok = 1'b1;
        q = lrb_read_data;
      end
    end
  endtask
endmodule
